// file: hdl/dws_core.v
// write burst sequencer: command decode, burst length, data capture, timers
`timescale 1ns/1ps
`include "dws_map.vh"
module dws_core #(
   parameter DW = 32,
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter GROUPS = 4,
   parameter GW = 2,
   parameter BANKS = 4,
   parameter BW = 2,
   parameter WTR_S = 4,
   parameter WTR_L = 8
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire wb_err_o,
   // command port from the controller
   input wire [2:0] cmd,
   input wire [GW-1:0] cmd_group,
   input wire [BW-1:0] cmd_bank,
   input wire burst_select_bit,
   input wire autoprecharge_bit,
   // write data lane
   input wire [DW-1:0] wdata,
   // status outputs
   output reg burst_active,
   output reg burst_chop_four,
   output reg recovery_start,
   output reg write_to_read_short,
   output reg write_to_read_long,
   output reg [BANKS*GROUPS-1:0] bank_open,
   output reg spacing_error,
   output reg overflow
);
////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_DATA = 3'b100;
wire [31:0] mode;
wire [1:0] burst_field;
wire pre2;
wire [5:0] write_latency;
wire [4:0] rec_time;
wire wr_cmd;
wire rd_cmd;
wire chop_now;
wire f_in_ready;
wire f_out_valid;
wire [DW-1:0] f_out_data;
wire rd_pop;
wire last_beat;
reg [2:0] state;
reg [5:0] lat_cnt;
reg [3:0] beat_cnt;
reg [3:0] beats;
reg close_pend;
reg [GW-1:0] cur_group;
reg [BW-1:0] cur_bank;
reg [4:0] rec_cnt;
reg [7:0] gap_cnt;
reg [15:0] wr_count;
reg [7:0] s_cnt [0:GROUPS-1];
reg [7:0] l_cnt [0:GROUPS-1];
reg next_short;
reg next_long;
integer g;
assign burst_field = mode[`DWS_BURST_MSB:`DWS_BURST_LSB];
assign pre2 = mode[`DWS_PRE2_BIT];
assign write_latency = {1'b0, mode[`DWS_CWL_MSB:`DWS_CWL_LSB]} +
   {1'b0, mode[`DWS_AL_MSB:`DWS_AL_LSB]};
assign rec_time = mode[`DWS_WR_MSB:`DWS_WR_LSB];
assign wr_cmd = (cmd == `DWS_CMD_WR);
assign rd_cmd = (cmd == `DWS_CMD_RD);
// chop select per burst field
assign chop_now = (burst_field == `DWS_BURST_BC4) ||
   ((burst_field == `DWS_BURST_OTF) && !burst_select_bit);
assign last_beat = (state == ST_DATA) && (beat_cnt == beats - 1'b1);
////////////////////////////////////////////////////////////////////////////
dws_wb_regs u_regs (
   .clk(clk),
   .resetn(resetn),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o),
   .mode(mode),
   .status({16'h0000, f_out_valid, ~f_in_ready, overflow, spacing_error,
      8'h00, 1'b0, state}),
   .wcount({16'h0000, wr_count}),
   .rdata(f_out_data[31:0]),
   .rdata_pop(rd_pop)
);
dws_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_fifo (
   .clk(clk),
   .resetn(resetn),
   .in_valid(state == ST_DATA),
   .in_ready(f_in_ready),
   .in_data(wdata),
   .out_valid(f_out_valid),
   .out_ready(rd_pop),
   .out_data(f_out_data)
);
////////////////////////////////////////////////////////////////////////////
// burst sequencer; a new write during a burst is the controller's hazard
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      state <= ST_IDLE;
      lat_cnt <= 6'h00;
      beat_cnt <= 4'h0;
      beats <= `DWS_BEATS_8;
      close_pend <= 1'b0;
      cur_group <= {GW{1'b0}};
      cur_bank <= {BW{1'b0}};
      burst_active <= 1'b0;
      burst_chop_four <= 1'b0;
      recovery_start <= 1'b0;
      overflow <= 1'b0;
      wr_count <= 16'h0000;
   end else begin
      recovery_start <= 1'b0;
      case (state)
         ST_IDLE: begin
            if (wr_cmd) begin
               beats <= chop_now ? `DWS_BEATS_4 : `DWS_BEATS_8;
               burst_chop_four <= chop_now;
               close_pend <= autoprecharge_bit;
               cur_group <= cmd_group;
               cur_bank <= cmd_bank;
               wr_count <= wr_count + 16'h0001;
               lat_cnt <= 6'h01;
               state <= (write_latency <= 6'h01) ? ST_DATA : ST_WAIT;
               burst_active <= (write_latency <= 6'h01);
               beat_cnt <= 4'h0;
            end
         end
         ST_WAIT: begin
            lat_cnt <= lat_cnt + 6'h01;
            if (lat_cnt + 6'h01 >= write_latency) begin
               state <= ST_DATA;
               burst_active <= 1'b1;
            end
         end
         ST_DATA: begin
            beat_cnt <= beat_cnt + 4'h1;
            if (!f_in_ready) begin
               overflow <= 1'b1;
            end
            if (last_beat) begin
               state <= ST_IDLE;
               burst_active <= 1'b0;
               recovery_start <= 1'b1;
            end
         end
         default: begin
            state <= ST_IDLE;
         end
      endcase
   end
end
////////////////////////////////////////////////////////////////////////////
// recovery counter closes the bank when autoclose was asked
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      rec_cnt <= 5'h00;
      bank_open <= {(BANKS*GROUPS){1'b0}};
   end else begin
      if (cmd == `DWS_CMD_OTHER) begin
         // other commands open the addressed bank; slots need no deselect
         bank_open[{cmd_group, cmd_bank}] <= 1'b1;
      end
      if (recovery_start && close_pend) begin
         rec_cnt <= rec_time;
      end else if (rec_cnt != 5'h00) begin
         rec_cnt <= rec_cnt - 5'h01;
         if (rec_cnt == 5'h01) begin
            bank_open[{cur_group, cur_bank}] <= 1'b0;
         end
      end
   end
end
////////////////////////////////////////////////////////////////////////////
// per-group write-to-read timers, started after the last beat
generate
   genvar gi;
   for (gi = 0; gi < GROUPS; gi = gi + 1) begin : g_tmr
      always @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            s_cnt[gi] <= 8'h00;
            l_cnt[gi] <= 8'h00;
         end else if (last_beat) begin
            s_cnt[gi] <= (cur_group == gi) ? 8'h00 : WTR_S[7:0];
            l_cnt[gi] <= (cur_group == gi) ? WTR_L[7:0] : 8'h00;
         end else begin
            if (s_cnt[gi] != 8'h00) s_cnt[gi] <= s_cnt[gi] - 8'h01;
            if (l_cnt[gi] != 8'h00) l_cnt[gi] <= l_cnt[gi] - 8'h01;
         end
      end
   end
endgenerate
always @* begin
   next_short = 1'b0;
   next_long = 1'b0;
   for (g = 0; g < GROUPS; g = g + 1) begin
      if (s_cnt[g] != 8'h00) next_short = 1'b1;
      if (l_cnt[g] != 8'h00) next_long = 1'b1;
   end
end
////////////////////////////////////////////////////////////////////////////
// flags controller spacing faults; the device keeps running regardless
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      gap_cnt <= 8'hFF;
      spacing_error <= 1'b0;
      write_to_read_short <= 1'b0;
      write_to_read_long <= 1'b0;
   end else begin
      write_to_read_short <= next_short;
      write_to_read_long <= next_long;
      if (wr_cmd) begin
         gap_cnt <= 8'h01;
      end else if (gap_cnt != 8'hFF) begin
         gap_cnt <= gap_cnt + 8'h01;
      end
      if (wr_cmd && pre2 && (gap_cnt == 8'h05)) begin
         spacing_error <= 1'b1;
      end
      if (pre2 && (mode[`DWS_CWL_MSB:`DWS_CWL_LSB] == `DWS_CWL_RST)) begin
         spacing_error <= 1'b1;
      end
      if (rd_cmd && ((l_cnt[cmd_group] != 8'h00) ||
         (s_cnt[cmd_group] != 8'h00))) begin
         spacing_error <= 1'b1;
      end
   end
end
endmodule

// file: hdl/dws_fifo.v
// synchronous valid/ready fifo for captured write data
`timescale 1ns/1ps
module dws_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wptr;
reg [AW-1:0] rptr;
reg [AW:0] count;
wire push;
wire pop;
assign in_ready = (count != DEPTH[AW:0]);
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rptr];
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;
always @(posedge clk) begin
   if (push) begin
      mem[wptr] <= in_data;
   end
end
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
   end else begin
      if (push) begin
         wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
         rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      if (push & ~pop) begin
         count <= count + 1'b1;
      end else if (pop & ~push) begin
         count <= count - 1'b1;
      end
   end
end
endmodule

// file: hdl/dws_map.vh
// register map, field positions and encodings of the write burst sequencer
`ifndef DWS_MAP_VH
`define DWS_MAP_VH
// wishbone word offsets (byte addresses)
`define DWS_REG_MODE 8'h00
`define DWS_REG_STAT 8'h04
`define DWS_REG_WCNT 8'h08
`define DWS_REG_DATA 8'h0C
// mode register fields
`define DWS_BURST_LSB 0
`define DWS_BURST_MSB 1
`define DWS_PRE2_BIT 2
`define DWS_CWL_LSB 8
`define DWS_CWL_MSB 12
`define DWS_AL_LSB 16
`define DWS_AL_MSB 20
`define DWS_WR_LSB 24
`define DWS_WR_MSB 28
// burst field encodings
`define DWS_BURST_BL8 2'h0
`define DWS_BURST_OTF 2'h1
`define DWS_BURST_BC4 2'h2
// reset values
`define DWS_CWL_RST 5'h09
`define DWS_AL_RST 5'h00
`define DWS_WR_RST 5'h0C
// beat counts
`define DWS_BEATS_8 4'h8
`define DWS_BEATS_4 4'h4
// command encodings on the command port
`define DWS_CMD_DES 3'h0
`define DWS_CMD_WR 3'h1
`define DWS_CMD_RD 3'h2
`define DWS_CMD_OTHER 3'h3
`endif

// file: hdl/dws_wb_regs.v
// wishbone classic slave holding the mode register and status reads
`timescale 1ns/1ps
`include "dws_map.vh"
module dws_wb_regs (
   // clock and reset
   input wire clk,
   input wire resetn,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   // block side
   output reg [31:0] mode,
   input wire [31:0] status,
   input wire [31:0] wcount,
   input wire [31:0] rdata,
   output reg rdata_pop
);
wire req;
wire hit;
integer i;
assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
assign hit = (wb_adr_i == `DWS_REG_MODE) || (wb_adr_i == `DWS_REG_STAT) ||
   (wb_adr_i == `DWS_REG_WCNT) || (wb_adr_i == `DWS_REG_DATA);
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      mode <= {3'h0, `DWS_WR_RST, 3'h0, `DWS_AL_RST, 3'h0, `DWS_CWL_RST,
         8'h00};
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      rdata_pop <= 1'b0;
   end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      rdata_pop <= 1'b0;
      if (req & wb_we_i & (wb_adr_i == `DWS_REG_MODE)) begin
         for (i = 0; i < 4; i = i + 1) begin
            if (wb_sel_i[i]) begin
               mode[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
         end
      end
      if (req & ~wb_we_i) begin
         if (wb_adr_i == `DWS_REG_MODE) begin
            wb_dat_o <= mode;
         end else if (wb_adr_i == `DWS_REG_STAT) begin
            wb_dat_o <= status;
         end else if (wb_adr_i == `DWS_REG_WCNT) begin
            wb_dat_o <= wcount;
         end else if (wb_adr_i == `DWS_REG_DATA) begin
            wb_dat_o <= rdata;
            // popping on read keeps one word per access
            rdata_pop <= 1'b1;
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end
end
endmodule

// file: test/dram_write_burst_sequencing_tb_top.sv
// testbench for the write burst sequencer
`timescale 1ns/1ps
`include "dws_map.vh"
module dram_write_burst_sequencing_tb_top;
   reg clk;
   reg resetn;
   reg wb_cyc_i;
   reg wb_stb_i;
   reg wb_we_i;
   reg [7:0] wb_adr_i;
   reg [3:0] wb_sel_i;
   reg [31:0] wb_dat_i;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, wb_err_o, burst_select_bit, autoprecharge_bit;
   wire [2:0] cmd;
   wire [1:0] cmd_group, cmd_bank;
   wire [31:0] wdata;
   wire burst_active, burst_chop_four, recovery_start, overflow;
   wire write_to_read_short, write_to_read_long, spacing_error;
   wire [15:0] bank_open;
   integer num_errors = 0;
   integer total_checks = 0;
   integer cycles = 0;
   integer beats = 0;
   integer i, k;
   reg [31:0] q, w0;
   reg e;
   dws_core dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cmd,
      .cmd_group, .cmd_bank, .burst_select_bit, .autoprecharge_bit, .wdata,
      .burst_active, .burst_chop_four, .recovery_start,
      .write_to_read_short, .write_to_read_long, .bank_open,
      .spacing_error, .overflow);
   dws_ctrl_model u_ctl (.clk, .cmd, .cmd_group, .cmd_bank,
      .burst_select_bit, .autoprecharge_bit, .wdata);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   /////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (burst_active)
         beats <= beats + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         test_done;
      end
   end
   task test_done;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         @(posedge clk);
         while (!(wb_ack_o || wb_err_o))
            @(posedge clk);
         q = wb_dat_o;
         e = wb_err_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   // write, then another command in a gap slot, then wait out recovery
   task burst(input [1:0] g, input bs, input ap);
      begin
         beats = 0;
         u_ctl.send(`DWS_CMD_WR, g, 2'h1, bs, ap);
         u_ctl.send(`DWS_CMD_OTHER, g, 2'h2, 1'b0, 1'b0);
         while (!recovery_start)
            @(posedge clk);
         repeat (16) @(posedge clk);
      end
   endtask
   // drain n words, each one step above the previous
   task drain(input integer n);
      begin
         for (k = 0; k < n; k = k + 1) begin
            wb(1'b0, `DWS_REG_DATA, 32'h0);
            if (k == 0)
               w0 = q;
            chk("fifo word", w0 + k, q);
         end
      end
   endtask
   /////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      wb(1'b0, `DWS_REG_MODE, 32'h0);
      chk("mode reset", 32'h0C000900, q);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      // modes 00, 01 high, 01 low, 10 high; latency kept at nine
      for (i = 0; i < 4; i = i + 1) begin
         wb(1'b1, `DWS_REG_MODE, 32'h0C000900 | ((i == 0) ? 0 :
            (i == 3) ? 2 : 1));
         u_ctl.send(`DWS_CMD_OTHER, i, 2'h1, 1'b0, 1'b0);
         burst(i, i[0], i[1]);
         chk("beats", (i < 2) ? 8 : 4, beats);
         chk("chop flag", i >= 2, burst_chop_four);
         chk("bank kept", !i[1], bank_open[i * 4 + 1]);
         chk("gap command", 1, bank_open[i * 4 + 2]);
         drain((i < 2) ? 8 : 4);
      end
      // fill to the brim with nobody draining, then one burst too many
      wb(1'b1, `DWS_REG_MODE, 32'h0C000900);
      burst(2'h0, 1'b0, 1'b0);
      burst(2'h1, 1'b0, 1'b0);
      wb(1'b0, `DWS_REG_STAT, 32'h0);
      chk("full stat", 32'hC000, q & 32'hF000);
      burst(2'h2, 1'b0, 1'b0);
      chk("overflow", 1, overflow);
      drain(8);
      drain(8);
      wb(1'b0, `DWS_REG_STAT, 32'h0);
      chk("empty stat", 32'h2000, q & 32'hB000);
      // read to the same group straight after the burst
      beats = 0;
      u_ctl.send(`DWS_CMD_WR, 2'h3, 2'h0, 1'b0, 1'b0);
      while (!recovery_start)
         @(posedge clk);
      u_ctl.send(`DWS_CMD_RD, 2'h3, 2'h0, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      chk("read too soon", 1, spacing_error);
      // mid-run reset, then 2-clock preamble with latency left at nine
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      chk("reset clears", 0, spacing_error);
      wb(1'b1, `DWS_REG_MODE, 32'h0C000904);
      repeat (2) @(posedge clk);
      chk("latency nine", 1, spacing_error);
      // reset again; legal latency, then writes only five apart
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      wb(1'b1, `DWS_REG_MODE, 32'h0C000A04);
      repeat (2) @(posedge clk);
      chk("latency ten", 0, spacing_error);
      u_ctl.send(`DWS_CMD_WR, 2'h0, 2'h0, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      u_ctl.send(`DWS_CMD_WR, 2'h1, 2'h0, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("writes five apart", 1, spacing_error);
      test_done;
   end
endmodule

// file: test/dws_chk_monitor.sv
// port checker for the write burst sequencer
`timescale 1ns/1ps
module dws_chk_monitor (
   // clock and reset
   input wire clk,
   input wire resetn,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [7:0] wb_adr_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   // status
   input wire burst_active,
   input wire burst_chop_four,
   input wire recovery_start,
   input wire write_to_read_short,
   input wire write_to_read_long,
   input wire spacing_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // taken only when no answer is pending
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   /////////////////////////////////////////////////////////////////////
   chk_burst_len:
   assert property ($fell(burst_active) |-> (burst_chop_four ?
      $past(burst_active, 4) && !$past(burst_active, 5) :
      $past(burst_active, 8) && !$past(burst_active, 9)))
      else $error("burst length wrong");
   chk_rec_edge:
   assert property ($fell(burst_active) |-> recovery_start)
      else $error("recovery not at edge after last beat");
   chk_rec_pulse:
   assert property (recovery_start |-> !burst_active ##1 !recovery_start)
      else $error("recovery pulse malformed");
   chk_wtr_start:
   assert property (recovery_start |->
      ##[1:2] (write_to_read_short && write_to_read_long))
      else $error("read delay timers not started");
   chk_short_len:
   assert property ($rose(write_to_read_short) |->
      write_to_read_short[*3] ##[1:3] !write_to_read_short)
      else $error("short read delay length wrong");
   chk_long_len:
   assert property ($rose(write_to_read_long) |->
      write_to_read_long[*7] ##[1:3] !write_to_read_long)
      else $error("long read delay length wrong");
   chk_wb_answer:
   assert property (req |=> wb_ack_o != wb_err_o)
      else $error("bus answer missing");
   chk_err_map:
   assert property (req && wb_adr_i > 8'h0C |=> wb_err_o)
      else $error("unmapped access not refused");
   chk_ack_pulse:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_err_hold:
   assert property (spacing_error |=> spacing_error)
      else $error("spacing error dropped");
endmodule
bind dws_core dws_chk_monitor u_mon (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
   .wb_adr_i, .wb_ack_o, .wb_err_o, .burst_active, .burst_chop_four,
   .recovery_start, .write_to_read_short, .write_to_read_long,
   .spacing_error);

// file: test/dws_ctrl_model.sv
// controller model driving commands and write data beats
`timescale 1ns/1ps
`include "dws_map.vh"
module dws_ctrl_model (
   // clock
   input wire clk,
   // command port
   output reg [2:0] cmd,
   output reg [1:0] cmd_group,
   output reg [1:0] cmd_bank,
   output reg burst_select_bit,
   output reg autoprecharge_bit,
   // data lane
   output reg [31:0] wdata
);
   initial begin
      cmd = `DWS_CMD_DES;
      cmd_group = 2'h0;
      cmd_bank = 2'h0;
      burst_select_bit = 1'b0;
      autoprecharge_bit = 1'b0;
      wdata = 32'h00000000;
   end
   // data moves every cycle, so a beat taken one slot off shows
   always @(posedge clk) begin
      wdata <= wdata + 32'h1;
   end
   // one-cycle command, fields inverted once deselected
   task send(input [2:0] c, input [1:0] g, input [1:0] b, input bs,
      input ap);
      begin
         @(posedge clk);
         cmd <= c;
         cmd_group <= g;
         cmd_bank <= b;
         burst_select_bit <= bs;
         autoprecharge_bit <= ap;
         @(posedge clk);
         cmd <= `DWS_CMD_DES;
         cmd_group <= ~g;
         cmd_bank <= ~b;
         burst_select_bit <= ~bs;
         autoprecharge_bit <= ~ap;
      end
   endtask
endmodule
